//--- src/dmse_regs.svh
`ifndef DMSE_REGS_SVH
`define DMSE_REGS_SVH

// ****************************************
// bus addressing and byte positions
// ****************************************
`define DMSE_DEV_ADDR 7'h50
`define DMSE_IDX_CTRL 2'h0
`define DMSE_IDX_ADDR 2'h1
`define DMSE_IDX_DATA 2'h2
`define DMSE_BYTE_BITS 4'h8

// ****************************************
// transmit-only stream
// ****************************************
`define DMSE_INIT_CLKS 4'h9
`define DMSE_NULL_POS 4'h8
`define DMSE_RECOVER_LAST 7'h7f
`define DMSE_TX_ADDR_RESET 7'h00
`define DMSE_PTR_RESET 8'h00

// ****************************************
// storage
// ****************************************
`define DMSE_MEM_WORDS 32'h0000_0100
`define DMSE_MEM_RESET 8'h00
`define DMSE_PAGE_DEPTH 32'h0000_0008

// ****************************************
// timing: 10 ms write, 10 MHz clock
// ****************************************
`define DMSE_TWR_MS 32'h0000_000a
`define DMSE_MCLK_HZ 32'h0098_9680
`define DMSE_MS_PER_S 32'h0000_03e8
`define DMSE_PROG_W 17

`endif

//--- src/dmse_pkg.sv
package dmse_pkg;

	typedef enum logic [3:0] {
		M_INIT = 4'h1,
		M_TXO = 4'h2,
		M_TRANS = 4'h4,
		M_BIDIR = 4'h8
	} dmse_mode_type;

	typedef enum logic [4:0] {
		I_IDLE = 5'h01,
		I_RX = 5'h02,
		I_ACK = 5'h04,
		I_TX = 5'h08,
		I_TXACK = 5'h10
	} dmse_i2c_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} dmse_wr_type;

endpackage

//--- src/dmse_sync.sv
`timescale 1ns/100ps
module dmse_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	// idle-high reset so no false edge at release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '1;
			q <= '1;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

//--- src/dmse_fifo.sv
`timescale 1ns/100ps
module dmse_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [AW-1:0] wrPtr_reg;
	logic [AW-1:0] rdPtr_reg;
	logic [AW:0] count_reg;
	wire pop = outValid & outReady;
	// a push into a full buffer is taken only when the oldest leaves together
	wire push = inValid & (inReady | pop);

	assign inReady = (count_reg != (AW+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData = store[rdPtr_reg];

	always_ff @(posedge clk) begin
		if (push) begin
			store[wrPtr_reg] <= inData;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wrPtr_reg <= AW'(wrPtr_reg + 1'h1);
			end
			if (pop) begin
				rdPtr_reg <= AW'(rdPtr_reg + 1'h1);
			end
			if (push && !pop) begin
				count_reg <= (AW+1)'(count_reg + 1'h1);
			end else if (pop && !push) begin
				count_reg <= (AW+1)'(count_reg - 1'h1);
			end
		end
	end
endmodule

//--- src/dmse_port.sv
// How it works
// R01: power-up enters transmit-only mode with stream pointer at 00h.
// R02: stream bytes go MSB first, each followed by a released null bit.
// R03: each new stream bit appears at a transmit clock rising edge.
// R04: stream addresses ascend and wrap from 7Fh back to 00h.
// R05: host keeps SCL high to stay in transmit-only mode.
// R06: first nine transmit clocks only synchronise; data line stays released.
// R07: tenth transmit clock rising edge drives MSB of location 00h.
// R08: falling SCL in transmit-only mode enters transition mode.
// R09: transition mode seeks control byte, counts transmit clocks; SCL fall clears count.
// R10: 128 clocks with SCL idle returns to streaming from 00h MSB.
// R11: control byte seen in transition mode locks bidirectional mode until power-up.
// R12: in bidirectional mode transmit clock level only enables writes.
// R13: bidirectional mode reaches all 256 bytes; streaming only the lower half.
// R14: answer only to address 1010000 plus direction bit.
// R15: SDA fall with SCL high is Start, SDA rise is Stop.
// R16: data changes only while SCL low; sampled on SCL rise.
// R17: more than eight write bytes keep only the last eight, oldest dropped.
// R18: receiver holds SDA low through the ninth clock as acknowledge.
// R19: no acknowledge at all while a programming cycle runs.
// R20: master withholds acknowledge to end read; device releases SDA.
// R21: control, word address, data, each acknowledged; Stop starts programming.
// R22: writes need transmit clock high during transfer; falling later never aborts.
// R23: self-timed programming finishes within 10 ms of Stop.
// R24: pointer advances by one after each byte access.
// R25: data line is only pulled low or released, never driven high.
`timescale 1ns/100ps
`include "dmse_regs.svh"
module dmse_port #(
	parameter int WRITE_CYCLES = `DMSE_TWR_MS * (`DMSE_MCLK_HZ / `DMSE_MS_PER_S)
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic transmitOnlyClock
);
	// ****************************************
	// declarations
	// ****************************************
	logic [2:0] pinSync;
	logic [2:0] pinPrev_reg;
	dmse_pkg::dmse_mode_type mode_reg;
	dmse_pkg::dmse_mode_type mode_next;
	dmse_pkg::dmse_i2c_type iState_reg;
	logic [3:0] initCnt_reg;
	logic [6:0] transCnt_reg;
	logic [3:0] txPos_reg;
	logic [6:0] txAddr_reg;
	logic txOe_reg;
	logic [3:0] bitCnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] rdShift_reg;
	logic [1:0] byteIdx_reg;
	logic rw_reg;
	logic i2cOe_reg;
	logic [7:0] ptr_reg;
	logic writeOk_reg;
	logic drain_reg;
	logic progWr_reg;
	logic [`DMSE_PROG_W-1:0] busyCnt_reg;
	logic [7:0] mem [0:`DMSE_MEM_WORDS-1];
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoOutReady;
	dmse_pkg::dmse_wr_type fifoIn;
	dmse_pkg::dmse_wr_type fifoOut;

	// ****************************************
	// pin sampling and bus conditions
	// ****************************************
	dmse_sync #(
		.WIDTH(3)
	) u_sync (
		.clk(mclk),
		.rst(rst),
		.d({transmitOnlyClock, sdaIn, scl}),
		.q(pinSync)
	);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pinPrev_reg <= '1;
		end else begin
			pinPrev_reg <= pinSync;
		end
	end

	wire sclS = pinSync[0];
	wire sdaS = pinSync[1];
	wire txS = pinSync[2];
	wire sclFall = pinPrev_reg[0] & ~sclS;
	wire sclRise = ~pinPrev_reg[0] & sclS;
	wire txRise = ~pinPrev_reg[2] & txS;
	wire startCond = sclS & pinPrev_reg[0] & pinPrev_reg[1] & ~sdaS; // R15
	wire stopCond = sclS & pinPrev_reg[0] & ~pinPrev_reg[1] & sdaS; // R15

	// ****************************************
	// decode
	// ****************************************
	wire isInit = (mode_reg == dmse_pkg::M_INIT);
	wire isTxo = (mode_reg == dmse_pkg::M_TXO);
	wire isTrans = (mode_reg == dmse_pkg::M_TRANS);
	wire isBidir = (mode_reg == dmse_pkg::M_BIDIR);
	wire i2cActive = isTrans | isBidir;
	wire progBusy = (busyCnt_reg != '0);
	wire byteDone = (iState_reg == dmse_pkg::I_RX) & sclFall & (bitCnt_reg == `DMSE_BYTE_BITS);
	wire addrHit = (shift_reg[7:1] == `DMSE_DEV_ADDR); // R14
	wire ctrlHit = addrHit & ~progBusy; // R19
	wire isCtrl = (byteIdx_reg == `DMSE_IDX_CTRL);
	wire ctrlMatch = byteDone & isCtrl & ctrlHit;
	wire ackByte = isCtrl ? ctrlHit : 1'h1;
	wire wordAddr = byteDone & (byteIdx_reg == `DMSE_IDX_ADDR) & ~rw_reg;
	wire push = byteDone & (byteIdx_reg == `DMSE_IDX_DATA) & ~rw_reg;
	wire recover = isTrans & txRise & sclS & (transCnt_reg == `DMSE_RECOVER_LAST) & ~ctrlMatch;
	wire ackPhase = (iState_reg == dmse_pkg::I_ACK) & rw_reg;
	wire loadRead = sclFall & (ackPhase | (iState_reg == dmse_pkg::I_TXACK));
	wire [7:0] rdByte = mem[ptr_reg];

	// ****************************************
	// operating mode
	// ****************************************
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			dmse_pkg::M_INIT: begin
				if (sclFall) begin
					mode_next = dmse_pkg::M_TRANS; // R08
				end else if (txRise && initCnt_reg == `DMSE_INIT_CLKS) begin
					mode_next = dmse_pkg::M_TXO; // R07
				end
			end
			dmse_pkg::M_TXO: begin
				if (sclFall) begin
					mode_next = dmse_pkg::M_TRANS; // R08
				end
			end
			dmse_pkg::M_TRANS: begin
				if (ctrlMatch) begin
					mode_next = dmse_pkg::M_BIDIR; // R11
				end else if (recover) begin
					mode_next = dmse_pkg::M_TXO; // R10
				end
			end
			default: begin
				mode_next = mode_reg; // R11
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_reg <= dmse_pkg::M_INIT; // R01
			initCnt_reg <= '0;
			transCnt_reg <= '0;
		end else begin
			mode_reg <= mode_next;
			if (isInit && txRise) begin
				initCnt_reg <= initCnt_reg + 4'h1; // R06
			end
			if (sclFall || !isTrans) begin
				transCnt_reg <= '0; // R09
			end else if (txRise) begin
				transCnt_reg <= transCnt_reg + 7'h01; // R09
			end
		end
	end

	// ****************************************
	// transmit-only stream
	// ****************************************
	wire txLoad = (isInit | isTrans) & (mode_next == dmse_pkg::M_TXO);
	wire txStep = isTxo & txRise & ~sclFall; // R03
	wire txWrap = (txPos_reg == `DMSE_NULL_POS);
	wire [3:0] txPosNext = (txLoad | txWrap) ? 4'h0 : txPos_reg + 4'h1;
	wire [6:0] txAddrNext = txLoad ? `DMSE_TX_ADDR_RESET : (txWrap ? txAddr_reg + 7'h01 : txAddr_reg); // R04
	wire [7:0] txByte = mem[{1'h0, txAddrNext}]; // R13
	wire txBit = (txPosNext == `DMSE_NULL_POS) | txByte[~txPosNext[2:0]]; // R02

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			txPos_reg <= '0;
			txAddr_reg <= `DMSE_TX_ADDR_RESET; // R01
			txOe_reg <= 1'h1; // R06
		end else if (txLoad || txStep) begin
			txPos_reg <= txPosNext;
			txAddr_reg <= txAddrNext;
			txOe_reg <= txBit; // R03
		end
	end

	// ****************************************
	// two-wire slave
	// ****************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			iState_reg <= dmse_pkg::I_IDLE;
			bitCnt_reg <= '0;
			shift_reg <= '0;
			rdShift_reg <= '0;
			byteIdx_reg <= `DMSE_IDX_CTRL;
			rw_reg <= 1'h0;
			i2cOe_reg <= 1'h1;
		end else if (!i2cActive || stopCond) begin
			iState_reg <= dmse_pkg::I_IDLE;
			i2cOe_reg <= 1'h1;
		end else if (startCond) begin
			iState_reg <= dmse_pkg::I_RX;
			bitCnt_reg <= '0;
			byteIdx_reg <= `DMSE_IDX_CTRL;
			i2cOe_reg <= 1'h1;
		end else if (loadRead) begin
			iState_reg <= dmse_pkg::I_TX;
			i2cOe_reg <= rdByte[7]; // R16
			rdShift_reg <= {rdByte[6:0], 1'h0};
			bitCnt_reg <= 4'h1;
		end else begin
			case (iState_reg)
				dmse_pkg::I_RX: begin
					if (sclRise) begin
						shift_reg <= {shift_reg[6:0], sdaS}; // R16
						bitCnt_reg <= bitCnt_reg + 4'h1;
					end else if (byteDone) begin
						iState_reg <= ackByte ? dmse_pkg::I_ACK : dmse_pkg::I_IDLE; // R14
						i2cOe_reg <= ~ackByte; // R18
						if (isCtrl) begin
							rw_reg <= shift_reg[0];
						end
					end
				end
				dmse_pkg::I_ACK: begin
					if (sclFall) begin
						iState_reg <= dmse_pkg::I_RX;
						i2cOe_reg <= 1'h1;
						bitCnt_reg <= '0;
						if (byteIdx_reg != `DMSE_IDX_DATA) begin
							byteIdx_reg <= byteIdx_reg + 2'h1;
						end
					end
				end
				dmse_pkg::I_TX: begin
					if (sclFall && bitCnt_reg == `DMSE_BYTE_BITS) begin
						iState_reg <= dmse_pkg::I_TXACK;
						i2cOe_reg <= 1'h1;
					end else if (sclFall) begin
						i2cOe_reg <= rdShift_reg[7]; // R16
						rdShift_reg <= {rdShift_reg[6:0], 1'h0};
						bitCnt_reg <= bitCnt_reg + 4'h1;
					end
				end
				dmse_pkg::I_TXACK: begin
					if (sclRise && sdaS) begin
						iState_reg <= dmse_pkg::I_IDLE; // R20
					end
				end
				default: begin
					iState_reg <= dmse_pkg::I_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// address pointer
	// ****************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ptr_reg <= `DMSE_PTR_RESET;
		end else if (wordAddr) begin
			ptr_reg <= shift_reg; // R21
		end else if (push) begin
			ptr_reg <= {ptr_reg[7:3], ptr_reg[2:0] + 3'h1}; // R24
		end else if (loadRead) begin
			ptr_reg <= ptr_reg + 8'h01; // R24 R13
		end
	end

	// ****************************************
	// page buffer and programming
	// ****************************************
	wire stopSeen = stopCond & i2cActive;
	wire progStart = stopSeen & fifoOutValid & writeOk_reg & ~drain_reg; // R21 R22
	wire drainPop = drain_reg & fifoOutValid;
	wire overwrite = push & ~fifoInReady; // R17
	wire memWe = drainPop & progWr_reg & isBidir;

	assign fifoIn = '{addr: ptr_reg, data: shift_reg};
	assign fifoOutReady = drainPop | overwrite;

	dmse_fifo #(
		.WIDTH($bits(dmse_pkg::dmse_wr_type)),
		.DEPTH(`DMSE_PAGE_DEPTH)
	) u_page (
		.clk(mclk),
		.rst(rst),
		.inValid(push),
		.inReady(fifoInReady),
		.inData(fifoIn),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.outData(fifoOut)
	);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			writeOk_reg <= 1'h0;
		end else if (startCond) begin
			writeOk_reg <= txS; // R12 R22
		end else if (!txS && !progBusy) begin
			writeOk_reg <= 1'h0; // R22
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			drain_reg <= 1'h0;
			progWr_reg <= 1'h0;
			busyCnt_reg <= '0;
		end else begin
			if (stopSeen && fifoOutValid) begin
				drain_reg <= 1'h1;
				progWr_reg <= writeOk_reg; // R12
			end else if (!fifoOutValid) begin
				drain_reg <= 1'h0;
			end
			if (progStart) begin
				busyCnt_reg <= `DMSE_PROG_W'(WRITE_CYCLES); // R23
			end else if (progBusy) begin
				busyCnt_reg <= busyCnt_reg - 1'h1; // R22
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `DMSE_MEM_WORDS; i++) begin
				mem[i] <= `DMSE_MEM_RESET;
			end
		end else if (memWe) begin
			mem[fifoOut.addr] <= fifoOut.data; // R21
		end
	end

	// ****************************************
	// data line
	// ****************************************
	assign sdaOut = 1'h0; // R25
	assign sdaOe = (isInit | isTxo) ? txOe_reg : i2cOe_reg;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_recover;
		isTrans && txRise && sclS && (transCnt_reg == `DMSE_RECOVER_LAST) && !ctrlMatch;
	endsequence
	sequence s_write_stop;
		stopSeen && fifoOutValid && writeOk_reg && !drain_reg;
	endsequence

	property p_init_ptr;
		isInit |-> (txAddr_reg == `DMSE_TX_ADDR_RESET);
	endproperty
	a_init_ptr: assert property (p_init_ptr) else $error("stream pointer not at start"); // R01
	property p_null_bit;
		(isTxo && txPos_reg == `DMSE_NULL_POS) |-> sdaOe;
	endproperty
	a_null_bit: assert property (p_null_bit) else $error("null bit driven low"); // R02
	property p_hold_bit;
		(isTxo && !txRise && !sclFall) |=> $stable(sdaOe);
	endproperty
	a_hold_bit: assert property (p_hold_bit) else $error("stream bit moved without clock"); // R03
	property p_wrap;
		(txStep && txWrap) |=> (txPos_reg == 4'h0) && (txAddr_reg == 7'($past(txAddr_reg) + 7'h01));
	endproperty
	a_wrap: assert property (p_wrap) else $error("stream address did not advance"); // R04
	property p_quiet_init;
		isInit |-> sdaOe;
	endproperty
	a_quiet_init: assert property (p_quiet_init) else $error("line driven during sync"); // R06
	property p_first_bit;
		(isInit && txRise && !sclFall && initCnt_reg == `DMSE_INIT_CLKS) |=> isTxo && (sdaOe == mem[0][7]);
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("first bit wrong"); // R07
	property p_enter_trans;
		((isInit || isTxo) && sclFall) |=> isTrans ##1 (transCnt_reg <= 7'h01);
	endproperty
	a_enter_trans: assert property (p_enter_trans) else $error("no transition mode"); // R08
	property p_recover;
		s_recover |=> isTxo && (txAddr_reg == `DMSE_TX_ADDR_RESET) && (txPos_reg == 4'h0);
	endproperty
	a_recover: assert property (p_recover) else $error("no return to streaming"); // R10
	property p_locked;
		isBidir |=> isBidir;
	endproperty
	a_locked: assert property (p_locked) else $error("left bidirectional mode"); // R11
	property p_busy_quiet;
		progBusy |-> (iState_reg != dmse_pkg::I_ACK);
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("acknowledge while busy"); // R19
	property p_launch;
		s_write_stop |=> progBusy && (busyCnt_reg == `DMSE_PROG_W'(WRITE_CYCLES));
	endproperty
	a_launch: assert property (p_launch) else $error("stop did not start programming"); // R21
	property p_bound;
		busyCnt_reg <= `DMSE_PROG_W'(WRITE_CYCLES);
	endproperty
	a_bound: assert property (p_bound) else $error("programming too long"); // R23
	property p_open_drain;
		!sdaOe |-> (sdaOut == 1'h0);
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("line driven high"); // R25
endmodule

//--- verification/dmse_host_model.sv
`timescale 1ns/100ps
// ********
// bus master and display host
// ********
module dmse_host_model #(
	parameter int H = 5
) (
	input wire logic mclk,
	input wire logic sdaLine,
	output logic scl,
	output logic sdaDrive,
	output logic transmitOnlyClock,
	output logic sampStb,
	output logic sampVal
);
	initial begin
		scl = 1'b1;
		sdaDrive = 1'b1;
		transmitOnlyClock = 1'b0;
		sampStb = 1'b0;
		sampVal = 1'b1;
	end

	task automatic wait_h();
		repeat (H) @(negedge mclk);
	endtask

	// one-cycle note of the wire level for the bench monitor
	task automatic strobe(input logic on);
		sampVal = sdaLine;
		sampStb = on;
		@(negedge mclk);
		sampStb = 1'b0;
	endtask

	// 800 ns period, sampled late in the low phase
	task automatic tx_clk_pulse();
		transmitOnlyClock = 1'b1;
		repeat (4) @(negedge mclk);
		transmitOnlyClock = 1'b0;
		repeat (3) @(negedge mclk);
		strobe(1'b1);
	endtask

	task automatic set_tx_clk(input logic v);
		transmitOnlyClock = v;
		wait_h();
	endtask

	task automatic scl_blip();
		scl = 1'b0;
		wait_h();
		scl = 1'b1;
		wait_h();
	endtask

	task automatic start();
		sdaDrive = 1'b1;
		wait_h();
		scl = 1'b1;
		wait_h();
		sdaDrive = 1'b0;
		wait_h();
		scl = 1'b0;
		wait_h();
	endtask

	task automatic stop();
		sdaDrive = 1'b0;
		wait_h();
		scl = 1'b1;
		wait_h();
		sdaDrive = 1'b1;
		wait_h();
	endtask

	// data only changes in the low phase
	task automatic bit_cycle(input logic b, input logic on);
		sdaDrive = b;
		wait_h();
		scl = 1'b1;
		wait_h();
		strobe(on);
		scl = 1'b0;
		wait_h();
	endtask

	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(b[i], 1'b0);
		end
		bit_cycle(1'b1, 1'b1);
	endtask

	task automatic recv_byte(input logic last);
		repeat (8) bit_cycle(1'b1, 1'b1);
		bit_cycle(last, 1'b0);
	endtask
endmodule

//--- verification/dmse_port_tb.sv
`timescale 1ns/100ps
module dmse_port_tb;
	localparam int WC = 200;
	localparam logic [1:0] K_HIZ = 2'h0;
	localparam logic [1:0] K_STREAM = 2'h1;
	localparam logic [1:0] K_ACK = 2'h2;
	localparam logic [1:0] K_DATA = 2'h3;
	typedef struct packed {
		logic v;
		logic [1:0] kind;
	} dmse_exp_type;

	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic scl;
	logic hostSda;
	logic toClk;
	logic sampStb;
	logic sampVal;
	logic sdaOut;
	logic sdaOe;
	// pull-up wire, low when either party pulls
	wire logic sdaLine = (sdaOe ? 1'b1 : sdaOut) & hostSda;
	int failCount = 0;
	int testsRun = 0;
	dmse_exp_type expQ[$];
	dmse_exp_type e;
	logic [7:0] memModel [256];

	always #50 mclk = ~mclk;

	dmse_port #(.WRITE_CYCLES(WC)) dut (.mclk(mclk), .rst(rst), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .transmitOnlyClock(toClk));
	dmse_host_model host (.mclk(mclk), .sdaLine(sdaLine), .scl(scl), .sdaDrive(hostSda),
		.transmitOnlyClock(toClk), .sampStb(sampStb), .sampVal(sampVal));

	// ********
	// checking and verdict
	// ********
	task automatic check(input logic seen, input logic want, input string what);
		testsRun++;
		if (seen !== want) begin
			failCount++;
			$display("[ERR] %0t %s: saw %b want %b", $time, what, seen, want);
		end
	endtask

	task automatic reportAndStop();
		$display("checks %0d, mismatches %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge mclk) begin
		if (sampStb === 1'b1) begin
			check(sdaOut, 1'b0, "data pin driven high");
			if (expQ.size() == 0)
				check(1'b1, 1'b0, "unexpected sample");
			else begin
				e = expQ.pop_front();
				case (e.kind)
					K_HIZ: check(sampVal, e.v, "line not released");
					K_STREAM: check(sampVal, e.v, "stream bit");
					K_ACK: check(sampVal, e.v, "acknowledge");
					default: check(sampVal, e.v, "read data");
				endcase
			end
		end
	end

	initial begin
		repeat (40000) @(posedge mclk);
		check(1'b1, 1'b0, "watchdog expired");
		reportAndStop();
	end

	// ********
	// stimulus helpers
	// ********
	task automatic note(input logic v, input logic [1:0] k);
		expQ.push_back('{v: v, kind: k});
	endtask

	// stream bytes of a cleared array: eight low bits, then the null bit
	task automatic pulses(input int n, input logic [1:0] k);
		for (int i = 0; i < n; i++) begin
			note((k == K_STREAM) ? logic'(i % 9 == 8) : 1'b1, k);
			host.tx_clk_pulse();
		end
	endtask

	task automatic send(input logic [7:0] b, input logic ack);
		note(ack, K_ACK);
		host.send_byte(b);
	endtask

	task automatic poll(input logic ack);
		host.start();
		send(8'ha0, ack);
		host.stop();
	endtask

	task automatic write_to(input logic [7:0] a, input int n, input logic kept);
		logic [7:0] d;
		host.start();
		send(8'ha0, 1'b0);
		send(a, 1'b0);
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			send(d, 1'b0);
			if (kept)
				memModel[{a[7:3], 3'(a[2:0] + 3'(i))}] = d;
		end
		host.stop();
	endtask

	task automatic read_from(input logic [7:0] a, input int n);
		logic [7:0] p;
		host.start();
		send(8'ha0, 1'b0);
		send(a, 1'b0);
		host.start();
		send(8'ha1, 1'b0);
		for (int i = 0; i < n; i++) begin
			p = a + 8'(i);
			for (int j = 7; j >= 0; j--) begin
				note(memModel[p][j], K_DATA);
			end
			host.recv_byte(logic'(i == n - 1));
		end
		host.stop();
	endtask

	// ********
	// scenarios
	// ********
	initial begin
		void'($urandom(32'h74cbae7c));
		for (int i = 0; i < 256; i++) begin
			memModel[i] = 8'h00;
		end
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		repeat (2) @(negedge mclk);
		pulses(9, K_HIZ);
		pulses(18, K_STREAM);
		host.scl_blip();
		pulses(100, K_HIZ);
		host.scl_blip();
		pulses(127, K_HIZ);
		pulses(9, K_STREAM);
		host.set_tx_clk(1'b1);
		poll(1'b1);
		host.start();
		send(8'ha2, 1'b1);
		host.stop();
		write_to(8'hb3, 10, 1'b1);
		host.set_tx_clk(1'b0);
		poll(1'b1);
		repeat (WC + 50) @(negedge mclk);
		poll(1'b0);
		read_from(8'hb0, 8);
		write_to(8'h42, 1, 1'b0);
		poll(1'b0);
		read_from(8'h42, 1);
		pulses(130, K_HIZ);
		repeat (20) @(negedge mclk);
		check(logic'(expQ.size() == 0), 1'b1, "samples missing");
		reportAndStop();
	end
endmodule
